/* File: include/mcr_pkg.sv */
// mcr_pkg: offsets, field positions, reset values and mode codes of the
// memory management and cache control register bank.
// assumes a 32-bit APB slave with byte addresses equal to the offsets below.
package mcr_pkg;

	// ==========================================================
	// register byte addresses
	localparam logic [31:0] TBL_BASE_OFF   = 32'h0483_0718;
	localparam logic [31:0] TBL_STRIDE     = 32'h0000_0020;
	localparam logic [31:0] DCTRL_OFF      = 32'h0483_0018;
	localparam logic [31:0] ICTRL_OFF      = 32'h0483_0020;
	localparam logic [31:0] MODE_OFF       = 32'h0483_0028;
	localparam logic [31:0] DBG_OFF        = 32'h0483_0030;
	localparam logic [31:0] DFLUSH_OFF     = 32'h0483_0038;
	localparam logic [31:0] IFLUSH_OFF     = 32'h0483_0040;
	localparam logic [31:0] DW0_OFF        = 32'h0483_0080;
	localparam logic [31:0] DW1_OFF        = 32'h0483_0090;
	localparam logic [31:0] LOC_EB_OFF     = 32'h0483_0600;
	localparam logic [31:0] GLB_EB_OFF     = 32'h0483_0608;
	localparam logic [31:0] WATTR_OFF      = 32'h0483_0640;
	localparam logic [31:0] WATTR_STRIDE   = 32'h0000_0008;

	// ==========================================================
	// writable bit masks
	localparam logic [31:0] TBL_MASK       = 32'hFFFF_FFFC;
	localparam logic [31:0] CTRL_MASK      = 32'h0000_0001;
	localparam logic [31:0] MODE_MASK      = 32'h0000_0007;
	localparam logic [31:0] EB_MASK        = 32'h0000_C0C0;
	localparam logic [31:0] WATTR_MASK     = 32'h0000_0077;
	localparam logic [31:0] DW_MASK        = 32'hFF80_C0DF;

	// ==========================================================
	// reset values
	localparam logic [31:0] TBL_RST        = 32'h0000_0000;
	localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
	localparam logic [31:0] MODE_RST       = 32'h0000_0000;
	localparam logic [31:0] EB_RST         = 32'h0000_0000;
	localparam logic [31:0] WATTR_RST      = 32'h0000_0007;
	localparam logic [31:0] DW_RST         = 32'h0000_0000;
	localparam logic        DFLUSH_RST     = 1'b1;
	localparam logic        IFLUSH_RST     = 1'b0;
	localparam logic        DBG_ACCESS_LEVEL_FLAG_RST   = 1'b1;

	// ==========================================================
	// field positions
	localparam int          MODE_LSB       = 0;
	localparam int          D_SKEW_BIT     = 6;
	localparam int          I_SKEW_BIT     = 5;
	localparam int          DBG_ACCESS_LEVEL_FLAG_BIT   = 2;
	localparam int          SLAVE_THR_LSB  = 4;
	localparam int          DEBUG_THR_LSB  = 0;
	localparam int          WATTR_WR_LSB   = 4;
	localparam int          WATTR_WM_LSB   = 0;
	localparam int          EB_IWIN_LSB    = 14;
	localparam int          EB_DWIN_LSB    = 6;
	localparam int          DW_HI_LSB      = 23;
	localparam int          DW_FMT_BIT     = 0;
	localparam int          SEL_ADDR_BASE  = 24;

	// ==========================================================
	// bypass mode codes and address-bit select codes
	localparam logic [2:0]  MODE_FULL      = 3'h7;
	localparam logic [2:0]  MODE_EB_BOTH   = 3'h6;
	localparam logic [2:0]  MODE_EB_I      = 3'h4;
	localparam logic [2:0]  MODE_EB_D      = 3'h2;
	localparam logic [2:0]  MODE_BYPASS    = 3'h0;
	localparam logic [2:0]  SEL_FIXED_ON   = 3'h0;
	localparam logic [2:0]  SEL_FIXED_OFF  = 3'h7;

	// ==========================================================
	// startup strap capture
	localparam logic [1:0]  STRAP_FILL     = 2'h3;

endpackage : mcr_pkg

/* File: verif/tb_top.sv */
// tb_top: self-checking bench of the cache and MMU control register bank.
// assumes mcr_regs with default parameters, APB master here, 100 MHz pclk.
module tb_top
	import mcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0, presetn = 0, pclken = 1, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, eb_addr = 0, eb_phys_addr;
	logic pready, pslverr, boot_self_pin = 0, dfl_done = 0, ifl_done = 0, eb_valid = 0;
	logic d_read_miss = 0, d_region_global = 0, i_read_miss = 0, i_region_global = 0;
	logic [1:0] slave_thread = 2'h2, debug_thread = 2'h1, eb_thread = 0;
	logic mmu_translate_en, dcache_eb_en, icache_eb_en, dcache_hit_en, icache_hit_en;
	logic dcache_flush_start, icache_flush_start, dbg_privileged, eb_writeable;
	logic eb_write_merge, eb_out_valid;
	logic [1:0] d_alloc_win, i_alloc_win, dw_enhanced;
	logic [119:0] table_base;
	logic [17:0] dw_phys_hi;
	logic [15:0] dw_flags;
	logic [31:0] ra [14], rm [14], rv [14], wd [14], a, lw, gw;
	int seed = 32'h9fcb_eca3;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;

	mcr_regs dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .boot_self_pin(boot_self_pin),
		.slave_thread(slave_thread), .debug_thread(debug_thread),
		.dcache_flush_done(dfl_done), .icache_flush_done(ifl_done),
		.d_read_miss(d_read_miss), .d_region_global(d_region_global),
		.i_read_miss(i_read_miss), .i_region_global(i_region_global), .eb_valid(eb_valid),
		.eb_thread(eb_thread), .eb_addr(eb_addr), .mmu_translate_en(mmu_translate_en),
		.dcache_eb_en(dcache_eb_en), .icache_eb_en(icache_eb_en),
		.dcache_hit_en(dcache_hit_en), .icache_hit_en(icache_hit_en),
		.dcache_flush_start(dcache_flush_start), .icache_flush_start(icache_flush_start),
		.d_alloc_win(d_alloc_win), .i_alloc_win(i_alloc_win), .dbg_privileged(dbg_privileged),
		.table_base(table_base), .dw_phys_hi(dw_phys_hi), .dw_flags(dw_flags),
		.dw_enhanced(dw_enhanced), .eb_writeable(eb_writeable), .eb_write_merge(eb_write_merge),
		.eb_phys_addr(eb_phys_addr), .eb_out_valid(eb_out_valid));

	always #5 pclk = ~pclk;

	// ==========================================================
	// checks and bus cycles
	task automatic print_verdict;
		if (fail_count == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("ERROR %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask : chk

	task automatic apb(input logic w, input logic [31:0] ad, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= ad;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [31:0] ad, input logic [31:0] exp, input logic ee);
		apb(1'b0, ad, 32'h0000_0000);
		chk("prdata", exp, prdata);
		chk("pslverr", ee, pslverr);
	endtask : rd

	// expected writeable, merge and cleared physical address
	function automatic logic [33:0] eb_exp(input int sw, input int sm, input logic [31:0] ad);
		logic [31:0] p;
		p = ad;
		if (sw > 0 && sw < 7)
			p[24 + sw] = 1'b0;
		if (sm > 0 && sm < 7)
			p[24 + sm] = 1'b0;
		return {(sw == 0) | (sw > 0 && sw < 7 && ad[24 + sw]), (sm == 7) | (sm > 0 && sm < 7 && ad[24 + sm]), p};
	endfunction : eb_exp

	// ==========================================================
	// main sequence
	initial
	begin
		for (int n = 0; n < 4; n++)
		begin
			ra[n] = TBL_BASE_OFF + TBL_STRIDE * n; rm[n] = TBL_MASK; rv[n] = TBL_RST;
			ra[4+n] = WATTR_OFF + WATTR_STRIDE * n; rm[4+n] = WATTR_MASK; rv[4+n] = WATTR_RST;
		end
		ra[8] = DW0_OFF; ra[9] = DW1_OFF; ra[10] = LOC_EB_OFF; ra[11] = GLB_EB_OFF;
		ra[12] = DCTRL_OFF; ra[13] = ICTRL_OFF;
		for (int i = 8; i < 14; i++)
		begin
			rm[i] = (i < 10) ? DW_MASK : (i < 12) ? EB_MASK : CTRL_MASK;
			rv[i] = (i < 10) ? DW_RST : (i < 12) ? EB_RST : CTRL_RST;
		end
		for (int b = 0; b < 2; b++)
		begin
			boot_self_pin <= b[0];
			presetn <= 1'b0;
			repeat (5) @(posedge pclk);
			presetn <= 1'b1;
			repeat (8) @(posedge pclk);
			rd(DBG_OFF, {26'h0, slave_thread, 1'b0, ~b[0], debug_thread}, 1'b0);
		end
		for (int i = 0; i < 14; i++)
			rd(ra[i], rv[i], 1'b0);
		rd(MODE_OFF, MODE_RST, 1'b0);
		rd(DFLUSH_OFF, 32'h0000_0001, 1'b0);
		rd(IFLUSH_OFF, 32'h0000_0000, 1'b0);
		for (int f = 0; f < 2; f++)
		begin
			apb(1'b1, f ? IFLUSH_OFF : DFLUSH_OFF, 32'h0000_0001);
			#1 chk("flush_start", 1, f ? icache_flush_start : dcache_flush_start);
			rd(f ? IFLUSH_OFF : DFLUSH_OFF, 32'h0000_0000, 1'b0);
			dfl_done <= !f;
			ifl_done <= f;
			@(posedge pclk);
			dfl_done <= 1'b0;
			ifl_done <= 1'b0;
			rd(f ? IFLUSH_OFF : DFLUSH_OFF, 32'h0000_0001, 1'b0);
		end
		for (int i = 0; i < 14; i++)
		begin
			wd[i] = $random(seed);
			wd[i][0] = (i == 9);
			apb(1'b1, ra[i], wd[i]);
		end
		for (int i = 0; i < 14; i++)
			rd(ra[i], wd[i] & rm[i], 1'b0);
		for (int n = 0; n < 4; n++)
			chk("table_base", wd[n][31:2], table_base[n*30 +: 30]);
		for (int w = 0; w < 2; w++)
		begin
			chk("dw_phys_hi", wd[8+w][31:23], dw_phys_hi[w*9 +: 9]);
			chk("dw_enhanced", wd[8+w][0], dw_enhanced[w]);
			chk("dw_flags", wd[8+w][0] ? {wd[8+w][15:14], wd[8+w][7:6], wd[8+w][4:1]} : 8'h00,
				dw_flags[w*8 +: 8]);
		end
		for (int p = 0; p < 2; p++)
		begin
			{slave_thread, debug_thread} <= $random(seed);
			apb(1'b1, DBG_OFF, p ? 32'h0000_0000 : 32'hFFFF_FFFF);
			#1 chk("dbg_privileged", !p, dbg_privileged);
			rd(DBG_OFF, {26'h0, slave_thread, 1'b0, !p, debug_thread}, 1'b0);
		end
		for (int en = 0; en < 2; en++)
		begin
			apb(1'b1, DCTRL_OFF, en);
			apb(1'b1, ICTRL_OFF, en);
			for (int m = 0; m < 8; m++)
			begin
				apb(1'b1, MODE_OFF, m);
				#1 chk("mode_outputs", {m == 7, m == 6 || m == 2, m == 6 || m == 4,
					en && (m == 7 || m == 6 || m == 2), en && (m == 7 || m == 6 || m == 4)},
					{mmu_translate_en, dcache_eb_en, icache_eb_en, dcache_hit_en, icache_hit_en});
			end
		end
		rd(MODE_OFF, 32'h0000_0007, 1'b0);
		for (int t = 0; t < 4; t++)
			for (int s = 0; s < 8; s++)
			begin
				apb(1'b1, WATTR_OFF + WATTR_STRIDE * t, {s[2:0], 1'b0, 3'(7 - s)});
				a = $random(seed);
				eb_valid <= 1'b1;
				eb_thread <= t[1:0];
				eb_addr <= a;
				@(posedge pclk);
				eb_valid <= 1'b0;
				#1 chk("eb_attr", eb_exp(s, 7 - s, a), {eb_writeable, eb_write_merge, eb_phys_addr});
				chk("eb_out_valid", 1, eb_out_valid);
			end
		lw = $random(seed);
		gw = $random(seed);
		apb(1'b1, LOC_EB_OFF, lw);
		apb(1'b1, GLB_EB_OFF, gw);
		for (int k = 0; k < 8; k++)
		begin
			@(posedge pclk);
			{i_region_global, d_region_global, d_read_miss} <= k[2:0];
			i_read_miss <= k[0];
			@(posedge pclk);
			#1 chk("d_alloc_win", k[0] ? (k[1] ? gw[7:6] : lw[7:6]) : 2'h0, d_alloc_win);
			chk("i_alloc_win", k[0] ? (k[2] ? gw[15:14] : lw[15:14]) : 2'h0, i_alloc_win);
		end
		rd(32'h0483_0048, 32'h0000_0000, 1'b1);
		print_verdict();
	end

endmodule : tb_top

/* File: verilog/mcr_eb_attr.sv */
// mcr_eb_attr: enhanced-bypass writeable and write-merge decode of one
// address, with the selecting address bit cleared in the physical address.
// assumes a same-clock request; results appear one cycle after eb_valid.
module mcr_eb_attr
	import mcr_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pclken,
	input  wire logic        eb_valid,
	input  wire logic [2:0]  sel_wr,
	input  wire logic [2:0]  sel_wm,
	input  wire logic [31:0] addr_in,
	output logic             writeable_reg,
	output logic             merge_reg,
	output logic [31:0]      phys_reg,
	output logic             valid_reg
);
	logic [31:0] clr_mask;
	logic        wr_bit;
	logic        wm_bit;

	// ==========================================================
	// decode
	always_comb
	begin
		clr_mask = 32'h0000_0000;
		wr_bit   = addr_in[SEL_ADDR_BASE + 32'(sel_wr)];
		wm_bit   = addr_in[SEL_ADDR_BASE + 32'(sel_wm)];
		if (sel_wr != SEL_FIXED_ON && sel_wr != SEL_FIXED_OFF)
			clr_mask[SEL_ADDR_BASE + 32'(sel_wr)] = 1'b1; // [R10]
		if (sel_wm != SEL_FIXED_ON && sel_wm != SEL_FIXED_OFF)
			clr_mask[SEL_ADDR_BASE + 32'(sel_wm)] = 1'b1; // [R10]
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			writeable_reg <= 1'b0;
			merge_reg     <= 1'b0;
			phys_reg      <= 32'h0000_0000;
			valid_reg     <= 1'b0;
		end
		else if (pclken)
		begin
			valid_reg <= eb_valid;
			if (eb_valid)
			begin
				case (sel_wr)
					SEL_FIXED_ON:  writeable_reg <= 1'b1; // [R8]
					SEL_FIXED_OFF: writeable_reg <= 1'b0; // [R8]
					default:       writeable_reg <= wr_bit; // [R8]
				endcase
				case (sel_wm)
					SEL_FIXED_ON:  merge_reg <= 1'b0; // [R9]
					SEL_FIXED_OFF: merge_reg <= 1'b1; // [R9]
					default:       merge_reg <= wm_bit; // [R9]
				endcase
				phys_reg <= addr_in & ~clr_mask; // [R10]
			end
		end
	end

	// ==========================================================
	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	never_writeable_a: assert property ( // [R8]
		(pclken && eb_valid && sel_wr == SEL_FIXED_OFF) |=> !writeable_reg)
		else $error("writeable set with select 7");
	merge_off_a: assert property ( // [R9]
		(pclken && eb_valid && sel_wm == SEL_FIXED_ON) |=> !merge_reg)
		else $error("write merge set with select 0");
	addr_bit_clear_a: assert property ( // [R10]
		(pclken && eb_valid && sel_wr != SEL_FIXED_ON && sel_wr != SEL_FIXED_OFF)
		|=> !phys_reg[SEL_ADDR_BASE + 32'($past(sel_wr))])
		else $error("selecting address bit not cleared");

endmodule : mcr_eb_attr

/* File: verilog/mcr_regs.sv */
// mcr_regs: APB register bank for translation tables, cache enables,
// bypass modes, cache flushes, debug port privilege and direct windows.
// assumes cache, MMU and debug logic on pclk; the boot strap is a pin.
//
// Operation
// [R1] per-thread global root table base in bits 31:2, stride 0x20
// [R2] data cache hits only when hit enable set and data cache not bypassed
// [R3] software flushes data cache before setting its hit enable
// [R4] instruction cache hits only when enable set and not bypassed
// [R5] software flushes instruction cache before setting its hit enable
// [R6] local and global allocation controls: window modes 15:14, 7:6, reset zero
// [R7] window modes apply only to line allocation on read miss
// [R8] per-thread writeable select: always, address bit 25..30, or never
// [R9] per-thread write-merge select: off, address bit 25..30, always; reset 7
// [R10] selected address bit reads zero in the produced physical address
// [R11] bypass mode field selects full translation, enhanced or plain bypass
// [R12] read-only skew support bits 6 and 5 for data and instruction cache
// [R13] debug control bit 2 makes debug and slave ports privileged
// [R14] privilege resets set; cleared after reset when the core boots itself
// [R15] self-booting code sets privilege bit when ready to hand over
// [R16] read-only bits 5:4 show the slave interface thread
// [R17] read-only bits 1:0 show the debug port thread
// [R18] data flush empties all lines; bit reads one when done; resets one
// [R19] instruction flush empties all lines; bit reads one when done; resets zero
// [R20] software uses the flushes only for initialisation after reset
// [R21] direct window registers give upper address bits 31:23 and attributes
// [R22] direct window bit 0 picks format; legacy uses only bits 31:23
module mcr_regs
	import mcr_pkg::*;
#(
	parameter int   NUM_THREADS = 4,
	parameter logic D_SKEW      = 1'b0,
	parameter logic I_SKEW      = 1'b0
)
(
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        pclken,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [31:0]                 paddr,
	input  wire logic [31:0]                 pwdata,
	output logic                             pready,
	output logic [31:0]                      prdata,
	output logic                             pslverr,
	input  wire logic                        boot_self_pin,
	input  wire logic [1:0]                  slave_thread,
	input  wire logic [1:0]                  debug_thread,
	input  wire logic                        dcache_flush_done,
	input  wire logic                        icache_flush_done,
	input  wire logic                        d_read_miss,
	input  wire logic                        d_region_global,
	input  wire logic                        i_read_miss,
	input  wire logic                        i_region_global,
	input  wire logic                        eb_valid,
	input  wire logic [1:0]                  eb_thread,
	input  wire logic [31:0]                 eb_addr,
	output logic                             mmu_translate_en,
	output logic                             dcache_eb_en,
	output logic                             icache_eb_en,
	output logic                             dcache_hit_en,
	output logic                             icache_hit_en,
	output logic                             dcache_flush_start,
	output logic                             icache_flush_start,
	output logic [1:0]                       d_alloc_win,
	output logic [1:0]                       i_alloc_win,
	output logic                             dbg_privileged,
	output logic [NUM_THREADS*30-1:0]        table_base,
	output logic [17:0]                      dw_phys_hi,
	output logic [15:0]                      dw_flags,
	output logic [1:0]                       dw_enhanced,
	output logic                             eb_writeable,
	output logic                             eb_write_merge,
	output logic [31:0]                      eb_phys_addr,
	output logic                             eb_out_valid
);
	logic [31:0] tbl_reg   [NUM_THREADS];
	logic [31:0] wattr_reg [NUM_THREADS];
	logic [31:0] dctrl_reg;
	logic [31:0] ictrl_reg;
	logic [31:0] mode_reg;
	logic [31:0] loc_eb_reg;
	logic [31:0] glb_eb_reg;
	logic [31:0] dw_reg    [2];
	logic        access_level_flag_reg;
	logic [1:0]  flush_reg;
	logic [1:0]  busy_reg;
	logic [1:0]  start_reg;
	logic [1:0]  flush_done;
	logic [1:0]  d_win_reg;
	logic [1:0]  i_win_reg;
	logic [31:0] prdata_reg;
	logic        pslverr_reg;
	logic [2:0]  strap_sync_reg;
	logic [1:0]  strap_fill_reg;
	logic        strap_taken_reg;
	logic        setup;
	logic        wr_en;
	logic        hit;
	logic [31:0] rd_next;
	logic [2:0]  mode;
	logic        d_cached;
	logic        i_cached;
	logic [1:0]  flush_wr;

	// ==========================================================
	// APB access
	assign setup   = psel && !penable;
	assign pready  = pclken;
	assign wr_en   = psel && penable && pwrite && pclken;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	always_comb
	begin
		hit     = 1'b1;
		rd_next = 32'h0000_0000;
		case (paddr)
			DCTRL_OFF:  rd_next = dctrl_reg;
			ICTRL_OFF:  rd_next = ictrl_reg;
			MODE_OFF:
			begin
				rd_next             = mode_reg;
				rd_next[D_SKEW_BIT] = D_SKEW; // [R12]
				rd_next[I_SKEW_BIT] = I_SKEW; // [R12]
			end
			DBG_OFF:
			begin
				rd_next[DBG_ACCESS_LEVEL_FLAG_BIT]              = access_level_flag_reg;
				rd_next[SLAVE_THR_LSB +: 2]        = slave_thread; // [R16]
				rd_next[DEBUG_THR_LSB +: 2]        = debug_thread; // [R17]
			end
			DFLUSH_OFF: rd_next[0] = flush_reg[0]; // [R18]
			IFLUSH_OFF: rd_next[0] = flush_reg[1]; // [R19]
			DW0_OFF:    rd_next = dw_reg[0];
			DW1_OFF:    rd_next = dw_reg[1];
			LOC_EB_OFF: rd_next = loc_eb_reg; // [R6]
			GLB_EB_OFF: rd_next = glb_eb_reg; // [R6]
			default:    hit = 1'b0;
		endcase
		for (int n = 0; n < NUM_THREADS; n++)
		begin
			if (paddr == TBL_BASE_OFF + 32'(n) * TBL_STRIDE)
			begin
				hit     = 1'b1;
				rd_next = tbl_reg[n];
			end
			if (paddr == WATTR_OFF + 32'(n) * WATTR_STRIDE)
			begin
				hit     = 1'b1;
				rd_next = wattr_reg[n];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
		else if (pclken && setup)
		begin
			prdata_reg  <= pwrite ? 32'h0000_0000 : rd_next;
			pslverr_reg <= !hit;
		end
	end

	// ==========================================================
	// control registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dctrl_reg  <= CTRL_RST;
			ictrl_reg  <= CTRL_RST;
			mode_reg   <= MODE_RST;
			loc_eb_reg <= EB_RST;
			glb_eb_reg <= EB_RST;
			dw_reg[0]  <= DW_RST;
			dw_reg[1]  <= DW_RST;
		end
		else if (wr_en)
		begin
			case (paddr)
				DCTRL_OFF:  dctrl_reg  <= pwdata & CTRL_MASK; // [R2]
				ICTRL_OFF:  ictrl_reg  <= pwdata & CTRL_MASK; // [R4]
				MODE_OFF:   mode_reg   <= pwdata & MODE_MASK; // [R11]
				LOC_EB_OFF: loc_eb_reg <= pwdata & EB_MASK; // [R6]
				GLB_EB_OFF: glb_eb_reg <= pwdata & EB_MASK; // [R6]
				DW0_OFF:    dw_reg[0]  <= pwdata & DW_MASK; // [R21]
				DW1_OFF:    dw_reg[1]  <= pwdata & DW_MASK; // [R21]
				default:    ;
			endcase
		end
	end

	// per-thread table bases and write attributes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int n = 0; n < NUM_THREADS; n++)
			begin
				tbl_reg[n]   <= TBL_RST;
				wattr_reg[n] <= WATTR_RST;
			end
		end
		else if (wr_en)
		begin
			for (int n = 0; n < NUM_THREADS; n++)
			begin
				if (paddr == TBL_BASE_OFF + 32'(n) * TBL_STRIDE)
					tbl_reg[n] <= pwdata & TBL_MASK; // [R1]
				if (paddr == WATTR_OFF + 32'(n) * WATTR_STRIDE)
					wattr_reg[n] <= pwdata & WATTR_MASK; // [R8] [R9]
			end
		end
	end

	always_comb
	begin
		for (int n = 0; n < NUM_THREADS; n++)
			table_base[n*30 +: 30] = tbl_reg[n][31:2]; // [R1]
	end

	// ==========================================================
	// bypass mode and hit enables
	assign mode             = mode_reg[MODE_LSB +: 3];
	assign mmu_translate_en = (mode == MODE_FULL); // [R11]
	assign dcache_eb_en     = (mode == MODE_EB_BOTH) || (mode == MODE_EB_D); // [R11]
	assign icache_eb_en     = (mode == MODE_EB_BOTH) || (mode == MODE_EB_I); // [R11]
	assign d_cached         = mmu_translate_en || dcache_eb_en;
	assign i_cached         = mmu_translate_en || icache_eb_en;
	assign dcache_hit_en    = dctrl_reg[0] && d_cached; // [R2]
	assign icache_hit_en    = ictrl_reg[0] && i_cached; // [R4]

	// ==========================================================
	// allocation window modes, only on a read miss
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			d_win_reg <= 2'h0;
			i_win_reg <= 2'h0;
		end
		else if (pclken)
		begin
			d_win_reg <= !d_read_miss ? 2'h0 : d_region_global ? // [R7]
				glb_eb_reg[EB_DWIN_LSB +: 2] : loc_eb_reg[EB_DWIN_LSB +: 2];
			i_win_reg <= !i_read_miss ? 2'h0 : i_region_global ? // [R7]
				glb_eb_reg[EB_IWIN_LSB +: 2] : loc_eb_reg[EB_IWIN_LSB +: 2];
		end
	end
	assign d_alloc_win = d_win_reg;
	assign i_alloc_win = i_win_reg;

	// ==========================================================
	// cache flushes: index 0 data, 1 instruction
	assign flush_wr[0] = wr_en && paddr == DFLUSH_OFF && pwdata[0];
	assign flush_wr[1] = wr_en && paddr == IFLUSH_OFF && pwdata[0];
	assign flush_done  = {icache_flush_done, dcache_flush_done};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			flush_reg <= {IFLUSH_RST, DFLUSH_RST}; // [R18] [R19]
			busy_reg  <= 2'h0;
			start_reg <= 2'h0;
		end
		else if (pclken)
		begin
			for (int k = 0; k < 2; k++)
			begin
				start_reg[k] <= flush_wr[k] && !busy_reg[k];
				if (busy_reg[k] && flush_done[k])
				begin
					flush_reg[k] <= 1'b1; // [R18] [R19]
					busy_reg[k]  <= 1'b0;
				end
				else if (flush_wr[k] && !busy_reg[k])
				begin
					flush_reg[k] <= 1'b0; // [R18] [R19]
					busy_reg[k]  <= 1'b1;
				end
			end
		end
	end
	assign dcache_flush_start = start_reg[0];
	assign icache_flush_start = start_reg[1];

	// ==========================================================
	// debug and slave port privilege
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			strap_sync_reg <= 3'h0;
		else if (pclken)
			strap_sync_reg <= {strap_sync_reg[1:0], boot_self_pin};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			access_level_flag_reg        <= DBG_ACCESS_LEVEL_FLAG_RST; // [R14]
			strap_fill_reg  <= 2'h0;
			strap_taken_reg <= 1'b0;
		end
		else if (pclken)
		begin
			if (strap_fill_reg != STRAP_FILL)
				strap_fill_reg <= strap_fill_reg + 2'h1;
			if (wr_en && paddr == DBG_OFF)
				access_level_flag_reg <= pwdata[DBG_ACCESS_LEVEL_FLAG_BIT]; // [R13] [R15]
			else if (!strap_taken_reg && strap_fill_reg == STRAP_FILL
				&& strap_sync_reg[1] == strap_sync_reg[2])
			begin
				access_level_flag_reg        <= !strap_sync_reg[2]; // [R14]
				strap_taken_reg <= 1'b1;
			end
			if (wr_en && paddr == DBG_OFF)
				strap_taken_reg <= 1'b1;
		end
	end
	assign dbg_privileged = access_level_flag_reg; // [R13]

	// ==========================================================
	// direct windows
	always_comb
	begin
		for (int w = 0; w < 2; w++)
		begin
			dw_phys_hi[w*9 +: 9] = dw_reg[w][31:DW_HI_LSB]; // [R21]
			dw_enhanced[w]       = dw_reg[w][DW_FMT_BIT]; // [R22]
			dw_flags[w*8 +: 8]   = dw_reg[w][DW_FMT_BIT] ? // [R22]
				{dw_reg[w][15:14], dw_reg[w][7:6], dw_reg[w][4:1]} : 8'h00;
		end
	end

	// ==========================================================
	// enhanced bypass write attributes
	mcr_eb_attr u_eb_attr (
		.pclk          (pclk),
		.presetn       (presetn),
		.pclken        (pclken),
		.eb_valid      (eb_valid),
		.sel_wr        (wattr_reg[eb_thread][WATTR_WR_LSB +: 3]),
		.sel_wm        (wattr_reg[eb_thread][WATTR_WM_LSB +: 3]),
		.addr_in       (eb_addr),
		.writeable_reg (eb_writeable),
		.merge_reg     (eb_write_merge),
		.phys_reg      (eb_phys_addr),
		.valid_reg     (eb_out_valid)
	);

	// ==========================================================
	// checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence dflush_req_s;
		flush_wr[0] && !busy_reg[0] && pclken;
	endsequence
	sequence dflush_wait_s;
		!flush_reg[0] && dcache_flush_start;
	endsequence

	dhit_gate_a: assert property ((!dctrl_reg[0] || !d_cached) |-> !dcache_hit_en) // [R2]
		else $error("data cache hits while disabled");
	ihit_gate_a: assert property ((mode == MODE_BYPASS) |-> !icache_hit_en) // [R4]
		else $error("instruction cache hits in bypass");
	alloc_win_a: assert property ((pclken && !d_read_miss) |=> d_alloc_win == 2'h0) // [R7]
		else $error("window mode outside allocation");
	eb_reserved_a: assert property (loc_eb_reg[13:8] == 6'h00 && glb_eb_reg[5:0] == 6'h00) // [R6]
		else $error("reserved allocation bits set");
	mode_full_a: assert property ((wr_en && paddr == MODE_OFF && pwdata[2:0] == MODE_FULL)
		|=> mmu_translate_en && dcache_eb_en == 1'b0) // [R11]
		else $error("full translation not selected");
	dflush_seq_a: assert property (dflush_req_s |=> dflush_wait_s) // [R18]
		else $error("data flush not started");
	iflush_done_a: assert property ((pclken && busy_reg[1] && icache_flush_done) // [R19]
		|=> flush_reg[1] && !busy_reg[1])
		else $error("instruction flush bit not set on completion");
	access_level_flag_write_a: assert property ((wr_en && paddr == DBG_OFF) // [R13]
		|=> dbg_privileged == $past(pwdata[DBG_ACCESS_LEVEL_FLAG_BIT]))
		else $error("privilege bit not written");
	tbl_low_a: assert property ((wr_en && paddr == TBL_BASE_OFF) |=> tbl_reg[0][1:0] == 2'h0) // [R1]
		else $error("table base reserved bits stored");
	dw_legacy_a: assert property (!dw_reg[0][DW_FMT_BIT] |-> dw_flags[7:0] == 8'h00) // [R22]
		else $error("legacy window drives attributes");

endmodule : mcr_regs
